// File: inc/uhbp_pkg.sv
// Package with shared constants and types of the UART host bus port.
package uhbp_pkg;
    // Bus widths.
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned REG_COUNT = 8;
    // Bus-style select levels.
    localparam logic STYLE_STROBE = 1'h1;
    localparam logic STYLE_DIRECTION = 1'h0;
    // Direction line levels in direction-line style.
    localparam logic DIR_READ = 1'h1;
    localparam logic DIR_WRITE = 1'h0;
    // Reset values.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] ADDR_RESET = 3'h0;
    // Host transfer timing: strobe hold time in ns, rounded up to whole clock cycles.
    localparam int unsigned STROBE_NS = 30;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);

    // Host sequencer states.
    typedef enum logic [4:0]
    {
        UHBP_IDLE = 5'h01,
        UHBP_SETUP = 5'h02,
        UHBP_ACTIVE = 5'h04,
        UHBP_RELEASE = 5'h08,
        UHBP_DONE = 5'h10
    } uhbp_state_type;
endpackage

// File: inc/uhbp_if.sv
// Interface carrying the host bus pins between the host and the UART port.
`timescale 1ns/1ps
interface uhbp_if;
    logic bus_style;
    logic [2:0] reg_select_addr;
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [7:0] data_from_host;
    logic data_oe_host;
    logic [7:0] data_from_dev;
    logic data_oe_dev;
    logic irq_out;
    logic irq_oe;
    logic [7:0] host_data_bus;
    logic irq_level;

    // Wire resolution of the shared data bus; the bus floats high when nobody drives.
    assign host_data_bus = data_oe_dev ? data_from_dev : (data_oe_host ? data_from_host : 8'hFF);
    // Strobe style drives or floats the line; direction style pulls low with an external pull-up.
    assign irq_level = irq_oe ? irq_out : (bus_style ? 1'h0 : 1'h1);

    modport dev
    (
        input bus_style, reg_select_addr, chip_select_n, read_strobe_n, write_strobe_n, host_data_bus,
        output data_from_dev, data_oe_dev, irq_out, irq_oe
    );
    modport host
    (
        output bus_style, reg_select_addr, chip_select_n, read_strobe_n, write_strobe_n,
        output data_from_host, data_oe_host,
        input host_data_bus, irq_level
    );
endinterface

// File: design/uhbp_device.sv
// Device end of the UART host bus port with its eight-byte register set.
`timescale 1ns/1ps
module uhbp_device
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_srst,
    // Host bus pins.
    uhbp_if.dev bus,
    // User side: interrupt request and control bit from the register core.
    input wire logic i_irq_pending,
    input wire logic i_alert_drive_enable,
    // User side: register contents and write event.
    output logic [63:0] o_reg_file,
    output logic o_write_pulse,
    output logic [2:0] o_write_addr
);
    logic [7:0] regs [0:7];
    logic [7:0] next_regs [0:7];
    logic prev_rd_n;
    logic prev_wr_n;
    logic prev_cs_n;
    logic rd_active;
    logic next_rd_active;
    logic [7:0] rd_data;
    logic [7:0] next_rd_data;
    logic [2:0] wr_addr;
    logic [2:0] next_wr_addr;
    logic [7:0] wr_data;
    logic [7:0] next_wr_data;
    logic wr_armed;
    logic next_wr_armed;
    logic wr_pulse;
    logic next_wr_pulse;
    logic irq_out;
    logic next_irq_out;
    logic irq_oe;
    logic next_irq_oe;
    logic sel;
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;
    logic cs_fall;
    logic cs_rise;

    // Edge detection on the host pins, which are taken as synchronous to the clock.
    always_comb
    begin
        sel = !bus.chip_select_n;
        rd_fall = prev_rd_n && !bus.read_strobe_n;
        rd_rise = !prev_rd_n && bus.read_strobe_n;
        wr_fall = prev_wr_n && !bus.write_strobe_n;
        wr_rise = !prev_wr_n && bus.write_strobe_n;
        cs_fall = prev_cs_n && !bus.chip_select_n;
        cs_rise = !prev_cs_n && bus.chip_select_n;
    end

    // Transfer sequencing for both bus styles.
    always_comb
    begin
        next_rd_active = rd_active;
        next_rd_data = rd_data;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_armed = wr_armed;
        next_wr_pulse = 1'h0;
        for (int i = 0; i < 8; i++)
        begin
            next_regs[i] = regs[i];
        end
        if (bus.bus_style == uhbp_pkg::STYLE_STROBE)
        begin
            if (rd_fall && sel)
            begin
                next_rd_active = 1'h1;
                next_rd_data = regs[bus.reg_select_addr];
            end
            else if (rd_rise || !sel)
            begin
                // Bus released once the host has sampled on the rising edge.
                next_rd_active = 1'h0;
            end
            if (wr_fall && sel)
            begin
                next_wr_armed = 1'h1;
            end
            if (wr_armed && !bus.write_strobe_n)
            begin
                // Address and data tracked during the strobe; the last low sample is loaded.
                next_wr_addr = bus.reg_select_addr;
                next_wr_data = bus.host_data_bus;
            end
            if (wr_armed && wr_rise)
            begin
                next_wr_armed = 1'h0;
                next_regs[wr_addr] = wr_data;
                next_wr_pulse = 1'h1;
            end
        end
        else
        begin
            // Direction style: chip select frames the transfer; the read strobe pin is not used.
            if (cs_fall)
            begin
                if (bus.write_strobe_n == uhbp_pkg::DIR_READ)
                begin
                    next_rd_active = 1'h1;
                    next_rd_data = regs[bus.reg_select_addr];
                end
                else
                begin
                    next_wr_armed = 1'h1;
                    next_wr_addr = bus.reg_select_addr;
                end
            end
            if (wr_armed && sel)
            begin
                next_wr_data = bus.host_data_bus;
            end
            if (cs_rise)
            begin
                next_rd_active = 1'h0;
                if (wr_armed)
                begin
                    next_wr_armed = 1'h0;
                    next_regs[wr_addr] = wr_data;
                    next_wr_pulse = 1'h1;
                end
            end
        end
    end

    // Interrupt pin drive per bus style.
    always_comb
    begin
        if (bus.bus_style == uhbp_pkg::STYLE_STROBE)
        begin
            next_irq_out = i_irq_pending;
            next_irq_oe = i_alert_drive_enable;
        end
        else
        begin
            // Open drain: only a low is ever driven.
            next_irq_out = 1'h0;
            next_irq_oe = i_irq_pending;
        end
    end

    // State registers.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            prev_rd_n <= 1'h1;
            prev_wr_n <= 1'h1;
            prev_cs_n <= 1'h1;
            rd_active <= 1'h0;
            rd_data <= uhbp_pkg::REG_RESET;
            wr_addr <= uhbp_pkg::ADDR_RESET;
            wr_data <= uhbp_pkg::REG_RESET;
            wr_armed <= 1'h0;
            wr_pulse <= 1'h0;
            irq_out <= 1'h0;
            irq_oe <= 1'h0;
            for (int i = 0; i < 8; i++)
            begin
                regs[i] <= uhbp_pkg::REG_RESET;
            end
        end
        else
        begin
            prev_rd_n <= bus.read_strobe_n;
            prev_wr_n <= bus.write_strobe_n;
            prev_cs_n <= bus.chip_select_n;
            rd_active <= next_rd_active;
            rd_data <= next_rd_data;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_armed <= next_wr_armed;
            wr_pulse <= next_wr_pulse;
            irq_out <= next_irq_out;
            irq_oe <= next_irq_oe;
            for (int i = 0; i < 8; i++)
            begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // Outputs straight from flip-flops.
    assign bus.data_from_dev = rd_data;
    assign bus.data_oe_dev = rd_active;
    assign bus.irq_out = irq_out;
    assign bus.irq_oe = irq_oe;
    assign o_write_pulse = wr_pulse;
    assign o_write_addr = wr_addr;

    // Flattened register view, register 0 in the low byte.
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_flat
            assign o_reg_file[g*8 +: 8] = regs[g];
        end
    endgenerate
endmodule

// File: design/uhbp_host.sv
// Host end of the UART host bus port: runs single register reads and writes.
`timescale 1ns/1ps
module uhbp_host
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_srst,
    // User side request.
    input wire logic i_style,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    // User side answer.
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic o_irq,
    // Host bus pins.
    uhbp_if.host bus
);
    uhbp_pkg::uhbp_state_type state;
    uhbp_pkg::uhbp_state_type next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic is_wr;
    logic next_is_wr;
    logic [2:0] addr;
    logic [2:0] next_addr;
    logic [7:0] wdata;
    logic [7:0] next_wdata;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic style;
    logic next_style;
    logic cs_n;
    logic next_cs_n;
    logic rd_n;
    logic next_rd_n;
    logic wr_n;
    logic next_wr_n;
    logic oe;
    logic next_oe;
    logic done;
    logic next_done;
    logic irq;
    logic next_irq;
    logic busy;
    logic next_busy;

    // Sequencer: setup, strobe for STROBE_CNT cycles, release with capture, done.
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_is_wr = is_wr;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = rdata;
        next_style = style;
        next_cs_n = cs_n;
        next_rd_n = 1'h1;
        next_wr_n = wr_n;
        next_oe = oe;
        next_done = 1'h0;
        // Active-high interrupt in strobe style, active low in direction style.
        next_irq = style ? bus.irq_level : !bus.irq_level;
        case (state)
            uhbp_pkg::UHBP_IDLE:
            begin
                next_wr_n = 1'h1;
                if (i_req)
                begin
                    next_is_wr = i_write;
                    next_addr = i_addr;
                    next_wdata = i_wdata;
                    next_style = i_style;
                    // Direction line set before chip select falls.
                    next_wr_n = i_style ? 1'h1 : (i_write ? uhbp_pkg::DIR_WRITE : uhbp_pkg::DIR_READ);
                    next_oe = i_write;
                    next_state = uhbp_pkg::UHBP_SETUP;
                end
            end
            uhbp_pkg::UHBP_SETUP:
            begin
                next_cs_n = 1'h0;
                next_cnt = uhbp_pkg::STROBE_CNT;
                if (style)
                begin
                    next_rd_n = is_wr;
                    next_wr_n = !is_wr;
                end
                next_state = uhbp_pkg::UHBP_ACTIVE;
            end
            uhbp_pkg::UHBP_ACTIVE:
            begin
                next_rd_n = !(style && !is_wr);
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1)
                begin
                    // Sample read data while still selected, then release the strobe.
                    next_rdata = bus.host_data_bus;
                    next_rd_n = 1'h1;
                    if (style)
                    begin
                        next_wr_n = 1'h1;
                    end
                    else
                    begin
                        next_cs_n = 1'h1;
                    end
                    next_state = uhbp_pkg::UHBP_RELEASE;
                end
            end
            uhbp_pkg::UHBP_RELEASE:
            begin
                // In strobe style chip select is kept past the strobe so the write lands while selected; direction style released it in UHBP_ACTIVE.
                next_cs_n = 1'h1;
                next_oe = 1'h0;
                next_state = uhbp_pkg::UHBP_DONE;
            end
            uhbp_pkg::UHBP_DONE:
            begin
                next_wr_n = 1'h1;
                next_done = 1'h1;
                next_state = uhbp_pkg::UHBP_IDLE;
            end
            default:
            begin
                next_state = uhbp_pkg::UHBP_IDLE;
            end
        endcase
        // Busy is registered so that the user sees it straight from a flip-flop.
        next_busy = (next_state != uhbp_pkg::UHBP_IDLE);
    end

    // State registers.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state <= uhbp_pkg::UHBP_IDLE;
            cnt <= 4'h0;
            is_wr <= 1'h0;
            addr <= uhbp_pkg::ADDR_RESET;
            wdata <= uhbp_pkg::REG_RESET;
            rdata <= uhbp_pkg::REG_RESET;
            style <= uhbp_pkg::STYLE_STROBE;
            cs_n <= 1'h1;
            rd_n <= 1'h1;
            wr_n <= 1'h1;
            oe <= 1'h0;
            done <= 1'h0;
            irq <= 1'h0;
            busy <= 1'h0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            is_wr <= next_is_wr;
            addr <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
            style <= next_style;
            cs_n <= next_cs_n;
            rd_n <= next_rd_n;
            wr_n <= next_wr_n;
            oe <= next_oe;
            done <= next_done;
            irq <= next_irq;
            busy <= next_busy;
        end
    end

    // Outputs straight from flip-flops.
    assign bus.bus_style = style;
    assign bus.reg_select_addr = addr;
    assign bus.chip_select_n = cs_n;
    assign bus.read_strobe_n = rd_n;
    assign bus.write_strobe_n = wr_n;
    assign bus.data_from_host = wdata;
    assign bus.data_oe_host = oe;
    assign o_busy = busy;
    assign o_done = done;
    assign o_rdata = rdata;
    assign o_irq = irq;
endmodule

// File: bench/uhbp_checker.sv
// Checker of the host bus pins between the host end and the device end.
`timescale 1ns/1ps
module uhbp_checker
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_srst,
    // Host bus pins.
    input wire logic bus_style,
    input wire logic [2:0] reg_select_addr,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic data_oe_host,
    input wire logic [7:0] data_from_dev,
    input wire logic data_oe_dev,
    input wire logic irq_out,
    input wire logic irq_oe
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    a_oe_needs_cs: assert property (chip_select_n && $past(chip_select_n) |-> !data_oe_dev)
        else $error("device drives data while not selected");
    a_no_contention: assert property (!(data_oe_dev && data_oe_host))
        else $error("both ends drive the data bus");
    a_write_no_drive: assert property (!write_strobe_n && !chip_select_n |-> !data_oe_dev)
        else $error("device drives data during a write");
    a_read_starts: assert property (bus_style && !chip_select_n && $fell(read_strobe_n) |-> ##[1:2] data_oe_dev)
        else $error("read strobe fall did not start a read");
    a_read_holds: assert property (bus_style && data_oe_dev && !read_strobe_n |=> data_oe_dev && $stable(data_from_dev))
        else $error("read byte not held until strobe rise");
    a_dir_read: assert property (!bus_style && $fell(chip_select_n) && write_strobe_n |-> ##[1:2] data_oe_dev)
        else $error("direction read not answered");
    a_open_drain: assert property (!bus_style && irq_oe |-> !irq_out)
        else $error("open drain interrupt driven high");
    a_rd_idle_dir: assert property (!bus_style |-> read_strobe_n)
        else $error("read strobe active in direction style");
    a_addr_stable: assert property (!chip_select_n && !$fell(chip_select_n) |-> $stable(reg_select_addr))
        else $error("address moved during a transfer");
endmodule

// File: bench/tb_top.sv
// Self-checking bench joining the host end to the device end, plus a bare device.
`timescale 1ns/1ps
module tb_top;
    logic i_clk = 1'h0;
    logic i_srst = 1'h1;
    logic style = 1'h1;
    logic req = 1'h0;
    logic wr = 1'h0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic pend = 1'h0;
    logic alert = 1'h0;
    logic busy;
    logic done;
    logic [7:0] rdata;
    logic irq;
    logic [63:0] regs;
    logic [63:0] regs_b;
    logic oe_seen;
    logic [7:0] bus_seen;
    logic wpulse;
    logic [2:0] waddr;
    logic [2:0] last_waddr = 3'h0;
    int n_wpulse = 0;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;

    uhbp_if bus();
    uhbp_if bus_b();

    uhbp_host i_uhbp_host (.i_clk(i_clk), .i_srst(i_srst), .i_style(style), .i_req(req), .i_write(wr),
        .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_irq(irq), .bus(bus));
    uhbp_device i_uhbp_device (.i_clk(i_clk), .i_srst(i_srst), .bus(bus), .i_irq_pending(pend),
        .i_alert_drive_enable(alert), .o_reg_file(regs), .o_write_pulse(wpulse), .o_write_addr(waddr));
    // The second device faces the bench directly so that a misbehaving host can be played.
    uhbp_device i_uhbp_device_b (.i_clk(i_clk), .i_srst(i_srst), .bus(bus_b), .i_irq_pending(1'h0),
        .i_alert_drive_enable(1'h0), .o_reg_file(regs_b), .o_write_pulse(), .o_write_addr());
    uhbp_checker i_uhbp_checker (.i_clk(i_clk), .i_srst(i_srst), .bus_style(bus.bus_style),
        .reg_select_addr(bus.reg_select_addr), .chip_select_n(bus.chip_select_n),
        .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
        .data_oe_host(bus.data_oe_host), .data_from_dev(bus.data_from_dev), .data_oe_dev(bus.data_oe_dev),
        .irq_out(bus.irq_out), .irq_oe(bus.irq_oe));

    // Free-running clock.
    always #5 i_clk = ~i_clk;

    // Write events of the joined device, sampled half a cycle after they are launched.
    always @(negedge i_clk)
    begin
        if (wpulse === 1'h1)
        begin
            n_wpulse++;
            last_waddr = waddr;
        end
    end

    // Cycle ceiling; the full run needs well under a thousand cycles.
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            stop_test();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Byte pattern that differs per address and per style, so stale data cannot match.
    function automatic logic [7:0] pat(input logic [2:0] a, input logic s);
        return 8'hA5 ^ {a, 2'h0, a} ^ {8{s}};
    endfunction

    // One host transfer; the request is held until the done pulse is seen.
    task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d);
        int k;
        @(negedge i_clk);
        wr = w;
        addr = a;
        wdata = d;
        req = 1'h1;
        k = 0;
        do
        begin
            @(negedge i_clk);
            k++;
            if (k == 1)
                check(64'(busy), 64'h1);
        end
        while (done !== 1'h1 && k < 40);
        req = 1'h0;
        check(64'(done), 64'h1);
        check(64'(busy), 64'h0);
    endtask

    // Raw strobe on the bare device, with chip select at the given level.
    task automatic strobe_b(input logic cs_n, input logic rd);
        @(negedge i_clk);
        bus_b.chip_select_n = cs_n;
        @(negedge i_clk);
        bus_b.read_strobe_n = !rd;
        bus_b.write_strobe_n = rd;
        repeat (3) @(negedge i_clk);
        oe_seen = bus_b.data_oe_dev;
        bus_seen = bus_b.host_data_bus;
        bus_b.read_strobe_n = 1'h1;
        bus_b.write_strobe_n = 1'h1;
        repeat (2) @(negedge i_clk);
        bus_b.chip_select_n = 1'h1;
        repeat (2) @(negedge i_clk);
    endtask

    // Main sequence: both styles through the joined ends, then the bare device.
    initial
    begin
        bus_b.bus_style = 1'h1;
        bus_b.reg_select_addr = 3'h5;
        bus_b.chip_select_n = 1'h1;
        bus_b.read_strobe_n = 1'h1;
        bus_b.write_strobe_n = 1'h1;
        bus_b.data_from_host = 8'h3C;
        bus_b.data_oe_host = 1'h1;
        repeat (8) @(negedge i_clk);
        i_srst = 1'h0;
        for (int s = 1; s >= 0; s--)
        begin
            style = s[0];
            for (int a = 0; a < 8; a++)
            begin
                xfer(1'h1, a[2:0], pat(a[2:0], s[0]));
                check(64'(last_waddr), 64'(a));
            end
            for (int a = 0; a < 8; a++)
            begin
                check(64'(regs[8*a +: 8]), 64'(pat(a[2:0], s[0])));
                xfer(1'h0, a[2:0], 8'h00);
                check(64'(rdata), 64'(pat(a[2:0], s[0])));
            end
            for (int m = 0; m < 4; m++)
            begin
                pend = m[0];
                alert = m[1];
                repeat (4) @(negedge i_clk);
                check({62'h0, bus.irq_oe, bus.irq_level}, {62'h0, s ? m[1] : m[0], s ? m[0] & m[1] : !m[0]});
                check(64'(irq), 64'(s ? m[0] & m[1] : m[0]));
            end
            // Interrupt inputs cleared before the style flips, since the pin drive lags the style by a cycle.
            pend = 1'h0;
            alert = 1'h0;
        end
        check(64'(n_wpulse), 64'h10);
        strobe_b(1'h1, 1'h0);
        check(regs_b, 64'h0);
        strobe_b(1'h1, 1'h1);
        check(64'(oe_seen), 64'h0);
        strobe_b(1'h0, 1'h0);
        check(regs_b, 64'h00003C0000000000);
        bus_b.data_oe_host = 1'h0;
        strobe_b(1'h0, 1'h1);
        check({55'h0, oe_seen, bus_seen}, {55'h0, 1'h1, 8'h3C});
        stop_test();
    end
endmodule
